// >>> jse_consts.svh
`ifndef JSE_CONSTS_SVH
`define JSE_CONSTS_SVH
// ==========================================================================
// Instruction word fields
`define JSE_OP_HI      23
`define JSE_OP_LO      18
`define JSE_IND_BIT    17
`define JSE_SUB_HI     17
`define JSE_SUB_LO     15
`define JSE_STOP_LO    12
`define JSE_B_HI       16
`define JSE_B_LO       15
`define JSE_M_HI       14
`define JSE_M_LO       0
// ==========================================================================
// Operation codes
`define JSE_OP_HALT    6'h00
`define JSE_OP_UJP     6'h01
`define JSE_OP_IDX     6'h02
`define JSE_OP_CMP     6'h03
`define JSE_OP_ADD     6'h18
`define JSE_OP_SUB     6'h19
`define JSE_OP_RAD     6'h1C
`define JSE_OP_OR      6'h1D
`define JSE_OP_XOR     6'h1E
`define JSE_OP_AND     6'h1F
`define JSE_OP_MUL     6'h28
`define JSE_OP_STOP    6'h3F
// ==========================================================================
// Sub codes
`define JSE_SUB_HALT   3'h0
`define JSE_SUB_RTJ    3'h7
`define JSE_STOP_SEL   6'h38
`define JSE_STOP_ALL   6'h3F
`define JSE_B_NONE     2'h0
// ==========================================================================
// Reset values and special words
`define JSE_PC_RST     15'h0000
`define JSE_WORD_RST   24'h000000
`define JSE_IDX_RST    15'h0000
`define JSE_IDX_NEGZ   15'h7FFF
`define JSE_IDX_M1     15'h7FFE
`define JSE_WORD_NEGZ  24'hFFFFFF
`define JSE_ONE15      15'h0001
`endif

// >>> jse_pkg.sv
`default_nettype none
// ==========================================================================
// Shared types of the execution unit
package jse_pkg;
  // Sequencer states
  typedef enum logic [2:0] {
    ST_FETCH  = 3'b000,
    ST_IWAIT  = 3'b001,
    ST_DECODE = 3'b010,
    ST_INDIR  = 3'b011,
    ST_EXEC   = 3'b100,
    ST_OPND   = 3'b101,
    ST_WRITE  = 3'b110,
    ST_HALT   = 3'b111
  } jse_state_t;
  // Compare jump conditions
  typedef enum logic [1:0] {
    COND_EQUAL            = 2'b00,
    COND_NOT_EQUAL        = 2'b01,
    COND_GREATER_OR_EQUAL = 2'b10,
    COND_LESS_THAN        = 2'b11
  } jse_cond_t;
endpackage : jse_pkg
`default_nettype wire

// >>> jse_exec.sv
`include "jse_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module jse_exec #(
  parameter int WORD_W = 24,
  parameter int ADDR_W = 15
) (
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst,
  // Core storage
  output var  logic              memReq,
  output var  logic              memWe,
  output var  logic [ADDR_W-1:0] memAddr,
  output var  logic [WORD_W-1:0] memWdata,
  input  wire logic              memAck,
  input  wire logic [WORD_W-1:0] memRdata,
  // Console
  input  wire logic              selStopSw,
  input  wire logic [5:0]        jumpKeys,
  input  wire logic              restart,
  // Machine state
  output var  logic              halted,
  output var  logic [ADDR_W-1:0] pc,
  output var  logic [WORD_W-1:0] accum,
  output var  logic [WORD_W-1:0] aux
);
  import jse_pkg::*;

  // ========================================================================
  // Elaboration check
  if (WORD_W != 24 || ADDR_W != 15) begin : g_badParams
    $error("jse_exec: word and address fields are fixed at 24 and 15 bits");
  end

  // ========================================================================
  // Helper functions
  // One's complement add with end-around carry
  function automatic logic [WORD_W-1:0] ocAdd(input logic [WORD_W-1:0] x,
                                              input logic [WORD_W-1:0] y);
    logic [WORD_W:0] s;
    s = {1'b0, x} + {1'b0, y};
    return s[WORD_W-1:0] + {{(WORD_W-1){1'b0}}, s[WORD_W]};
  endfunction : ocAdd

  // Either zero of one's complement
  function automatic logic isZero(input logic [WORD_W-1:0] x);
    return (x == `JSE_WORD_RST) || (x == `JSE_WORD_NEGZ);
  endfunction : isZero

  // Condition decode shared by both compare jumps
  function automatic logic condHit(input logic [1:0] j, input logic eq,
                                   input logic lt);
    case (jse_cond_t'(j))
      COND_EQUAL:            return eq;
      COND_NOT_EQUAL:        return !eq;
      COND_GREATER_OR_EQUAL: return !lt;
      COND_LESS_THAN:        return lt;
      default:               return 1'b0;
    endcase
  endfunction : condHit

  // One's complement multiply, 48-bit result
  function automatic logic [2*WORD_W-1:0] ocMul(input logic [WORD_W-1:0] x,
                                                input logic [WORD_W-1:0] y);
    logic [2*WORD_W-1:0] p;
    logic [WORD_W-1:0]   mx;
    logic [WORD_W-1:0]   my;
    mx = x[WORD_W-1] ? ~x : x;
    my = y[WORD_W-1] ? ~y : y;
    p  = {{WORD_W{1'b0}}, mx} * {{WORD_W{1'b0}}, my};
    return (x[WORD_W-1] ^ y[WORD_W-1]) ? ~p : p;
  endfunction : ocMul

  // Index increment that skips negative zero
  function automatic logic [ADDR_W-1:0] idxInc(input logic [ADDR_W-1:0] x);
    logic [ADDR_W:0]   t;
    logic [ADDR_W-1:0] r;
    t = {1'b0, x} + {1'b0, `JSE_ONE15};
    r = t[ADDR_W-1:0] + {{(ADDR_W-1){1'b0}}, t[ADDR_W]};
    return (r == `JSE_IDX_NEGZ) ? `JSE_IDX_RST : r;
  endfunction : idxInc

  // ========================================================================
  // Registers
  jse_state_t        state;
  jse_state_t        next_state;
  logic [WORD_W-1:0] ir;
  logic [WORD_W-1:0] next_ir;
  logic [ADDR_W-1:0] ea;
  logic [ADDR_W-1:0] next_ea;
  logic [ADDR_W-1:0] next_pc;
  logic [WORD_W-1:0] next_accum;
  logic [WORD_W-1:0] next_aux;
  logic              next_memReq;
  logic              next_memWe;
  logic [ADDR_W-1:0] next_memAddr;
  logic [WORD_W-1:0] next_memWdata;
  logic [ADDR_W-1:0] idx [1:3];
  logic              idxWe;
  logic [ADDR_W-1:0] idxVal;

  // Instruction fields
  logic [5:0]        op;
  logic [2:0]        sub;
  logic [1:0]        bSel;
  logic [ADDR_W-1:0] mField;
  logic [ADDR_W-1:0] seqPc;
  logic [ADDR_W-1:0] ixCur;
  logic [ADDR_W-1:0] ixRd;
  logic              modOk;
  assign op     = ir[`JSE_OP_HI:`JSE_OP_LO];
  assign sub    = ir[`JSE_SUB_HI:`JSE_SUB_LO];
  assign bSel   = ir[`JSE_B_HI:`JSE_B_LO];
  assign mField = ir[`JSE_M_HI:`JSE_M_LO];
  assign seqPc  = pc + `JSE_ONE15;
  assign ixCur  = (bSel == `JSE_B_NONE) ? `JSE_IDX_RST : idx[bSel];
  assign ixRd   = (memRdata[`JSE_B_HI:`JSE_B_LO] == `JSE_B_NONE) ? `JSE_IDX_RST
                : idx[memRdata[`JSE_B_HI:`JSE_B_LO]];
  // Only the unconditional jump and the logic and arithmetic ops take indexing and indirection
  assign modOk  = (op == `JSE_OP_UJP) || (op == `JSE_OP_ADD) || (op == `JSE_OP_SUB)
               || (op == `JSE_OP_RAD) || (op == `JSE_OP_OR) || (op == `JSE_OP_XOR)
               || (op == `JSE_OP_AND) || (op == `JSE_OP_MUL);

  // ========================================================================
  // Sequencer and datapath next values
  always_comb begin
    next_state    = state;
    next_ir       = ir;
    next_ea       = ea;
    next_pc       = pc;
    next_accum    = accum;
    next_aux      = aux;
    next_memReq   = memReq;
    next_memWe    = memWe;
    next_memAddr  = memAddr;
    next_memWdata = memWdata;
    idxWe         = 1'b0;
    idxVal        = ixCur;
    case (state)
      ST_FETCH: begin
        next_memReq  = 1'b1;
        next_memWe   = 1'b0;
        next_memAddr = pc;
        next_state   = ST_IWAIT;
      end
      ST_IWAIT: if (memAck) begin
        next_memReq = 1'b0;
        next_ir     = memRdata;
        next_state  = ST_DECODE;
      end
      ST_DECODE: begin
        // Indexed address, then optional indirect fetch
        next_ea = modOk ? mField + ixCur : mField;
        if (modOk && ir[`JSE_IND_BIT]) begin
          next_memReq  = 1'b1;
          next_memAddr = mField + ixCur;
          next_state   = ST_INDIR;
        end else begin
          next_state = ST_EXEC;
        end
      end
      ST_INDIR: if (memAck) begin
        next_ea = memRdata[`JSE_M_HI:`JSE_M_LO] + ixRd;
        if (memRdata[`JSE_IND_BIT]) begin
          next_memAddr = memRdata[`JSE_M_HI:`JSE_M_LO] + ixRd;
        end else begin
          next_memReq = 1'b0;
          next_state  = ST_EXEC;
        end
      end
      ST_EXEC: begin
        next_pc    = seqPc;
        next_state = ST_FETCH;
        case (op)
          `JSE_OP_HALT: begin
            if (sub == `JSE_SUB_HALT) begin
              next_pc    = ea;
              next_state = ST_HALT;
            end else if (sub == `JSE_SUB_RTJ) begin
              next_pc      = pc;
              next_memReq  = 1'b1;
              next_memAddr = ea;
              next_state   = ST_OPND;
            end else if (jumpKeys[sub-3'h1]) begin
              next_pc = ea;
            end
          end
          `JSE_OP_UJP: next_pc = ea;
          `JSE_OP_IDX: begin
            // Designator zero or a zero register falls through
            if (bSel != `JSE_B_NONE && ixCur != `JSE_IDX_RST) begin
              idxWe   = 1'b1;
              idxVal  = ir[`JSE_IND_BIT] ? ixCur - `JSE_ONE15
                                         : idxInc(ixCur);
              next_pc = ea;
            end
          end
          `JSE_OP_CMP: begin
            if (!ir[`JSE_IND_BIT]) begin
              if (condHit(bSel, isZero(accum), accum[WORD_W-1])) begin
                next_pc = ea;
              end
            end else if (condHit(bSel, (accum == aux) || (isZero(accum) && isZero(aux)),
                                 $signed(accum) < $signed(aux))) begin
              next_pc = ea;
            end
          end
          `JSE_OP_STOP: begin
            if (ir[`JSE_SUB_HI:`JSE_STOP_LO] == `JSE_STOP_ALL) begin
              next_state = ST_HALT;
            end else if (ir[`JSE_SUB_HI:`JSE_STOP_LO] == `JSE_STOP_SEL && selStopSw) begin
              next_state = ST_HALT;
            end
          end
          `JSE_OP_ADD, `JSE_OP_SUB, `JSE_OP_RAD, `JSE_OP_OR,
          `JSE_OP_XOR, `JSE_OP_AND, `JSE_OP_MUL: begin
            next_pc      = pc;
            next_memReq  = 1'b1;
            next_memAddr = ea;
            next_state   = ST_OPND;
          end
          default: next_pc = seqPc;
        endcase
      end
      ST_OPND: if (memAck) begin
        next_memReq = 1'b0;
        next_pc     = seqPc;
        next_state  = ST_FETCH;
        case (op)
          `JSE_OP_ADD: next_accum = ocAdd(accum, memRdata);
          `JSE_OP_SUB: next_accum = ocAdd(accum, ~memRdata);
          `JSE_OP_OR:  next_accum = accum | memRdata;
          `JSE_OP_XOR: next_accum = accum ^ memRdata;
          `JSE_OP_AND: next_accum = accum & memRdata;
          `JSE_OP_MUL: {next_aux, next_accum} = ocMul(accum, memRdata);
          `JSE_OP_RAD: begin
            next_pc       = pc;
            next_memReq   = 1'b1;
            next_memWe    = 1'b1;
            next_memWdata = ocAdd(memRdata, accum);
            next_state    = ST_WRITE;
          end
          `JSE_OP_HALT: begin
            // Return jump rewrites only the address field
            next_pc       = pc;
            next_memReq   = 1'b1;
            next_memWe    = 1'b1;
            next_memWdata = {memRdata[WORD_W-1:ADDR_W], seqPc};
            next_state    = ST_WRITE;
          end
          default: next_accum = accum;
        endcase
      end
      ST_WRITE: if (memAck) begin
        next_memReq = 1'b0;
        next_memWe  = 1'b0;
        next_pc     = (op == `JSE_OP_HALT) ? ea + `JSE_ONE15 : seqPc;
        next_state  = ST_FETCH;
      end
      ST_HALT: if (restart) begin
        next_state = ST_FETCH;
      end
      default: next_state = ST_FETCH;
    endcase
  end

  // ========================================================================
  // State and instruction registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state  <= ST_FETCH;
      ir     <= `JSE_WORD_RST;
      ea     <= `JSE_PC_RST;
      halted <= 1'b0;
    end else begin
      state  <= next_state;
      ir     <= next_ir;
      ea     <= next_ea;
      halted <= (next_state == ST_HALT);
    end
  end

  // Program counter and arithmetic registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pc    <= `JSE_PC_RST;
      accum <= `JSE_WORD_RST;
      aux   <= `JSE_WORD_RST;
    end else begin
      pc    <= next_pc;
      accum <= next_accum;
      aux   <= next_aux;
    end
  end

  // Index registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int i = 1; i <= 3; i++) begin
        idx[i] <= `JSE_IDX_RST;
      end
    end else if (idxWe) begin
      idx[bSel] <= idxVal;
    end
  end

  // Core storage port
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      memReq   <= 1'b0;
      memWe    <= 1'b0;
      memAddr  <= `JSE_PC_RST;
      memWdata <= `JSE_WORD_RST;
    end else begin
      memReq   <= next_memReq;
      memWe    <= next_memWe;
      memAddr  <= next_memAddr;
      memWdata <= next_memWdata;
    end
  end

  // ========================================================================
  // Checks
  haltResume_a: assert property (@(posedge sys_clk) disable iff (rst)
    state == ST_EXEC && op == `JSE_OP_HALT && sub == `JSE_SUB_HALT
    |=> halted && pc == $past(ea))
    else $error("halt did not hold the m address");
  ucsStop_a: assert property (@(posedge sys_clk) disable iff (rst)
    state == ST_EXEC && op == `JSE_OP_STOP && ir[`JSE_SUB_HI:`JSE_STOP_LO] == `JSE_STOP_ALL
    |=> halted && pc == $past(seqPc))
    else $error("unconditional stop misbehaved");
  slsPass_a: assert property (@(posedge sys_clk) disable iff (rst)
    state == ST_EXEC && op == `JSE_OP_STOP && !selStopSw
    && ir[`JSE_SUB_HI:`JSE_STOP_LO] == `JSE_STOP_SEL
    |=> !halted && pc == $past(seqPc))
    else $error("selective stop halted with switch off");
  keyJump_a: assert property (@(posedge sys_clk) disable iff (rst)
    state == ST_EXEC && op == `JSE_OP_HALT && sub == 3'h1
    |=> pc == ($past(jumpKeys[0]) ? $past(ea) : $past(seqPc)))
    else $error("key jump took wrong path");
  idxNop_a: assert property (@(posedge sys_clk) disable iff (rst)
    state == ST_EXEC && op == `JSE_OP_IDX && bSel == `JSE_B_NONE
    |=> pc == $past(seqPc))
    else $error("index jump with no designator jumped");
  idxWrap_a: assert property (@(posedge sys_clk) disable iff (rst)
    state == ST_EXEC && op == `JSE_OP_IDX && !ir[`JSE_IND_BIT] && bSel == 2'h1
    && idx[1] == `JSE_IDX_M1 |=> idx[1] == `JSE_IDX_RST)
    else $error("index count produced negative zero");
  negZeroEq_a: assert property (@(posedge sys_clk) disable iff (rst)
    state == ST_EXEC && op == `JSE_OP_CMP && !ir[`JSE_IND_BIT] && bSel == 2'h0
    && accum == `JSE_WORD_NEGZ |=> pc == $past(ea))
    else $error("negative zero not equal to zero");
  jumpFetch_a: assert property (@(posedge sys_clk) disable iff (rst)
    state == ST_EXEC && op == `JSE_OP_UJP
    |=> pc == $past(ea) ##1 memReq && !memWe && memAddr == pc)
    else $error("jump target not fetched");
  andOp_a: assert property (@(posedge sys_clk) disable iff (rst)
    state == ST_OPND && memAck && op == `JSE_OP_AND
    |=> accum == ($past(accum) & $past(memRdata)))
    else $error("logical product wrong");
  radKeep_a: assert property (@(posedge sys_clk) disable iff (rst)
    state == ST_OPND && memAck && op == `JSE_OP_RAD
    |=> memReq && memWe && memAddr == ea && accum == $past(accum))
    else $error("replace add disturbed accumulator");
endmodule : jse_exec
`default_nettype wire

// >>> jse_core_mem.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// Core storage model: one word per request, ack after a chosen wait
module jse_core_mem (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // Storage bus
  input  wire logic        memReq,
  input  wire logic        memWe,
  input  wire logic [14:0] memAddr,
  input  wire logic [23:0] memWdata,
  output var  logic        memAck,
  output var  logic [23:0] memRdata,
  // Extra wait cycles before each ack
  input  wire logic [1:0]  waitCycles
);
  logic [23:0] mem [0:32767];
  logic [1:0]  waited;

  // Count the wait of the request in flight; exactly one ack per request
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      memAck   <= 1'b0;
      memRdata <= 24'h5A5A5A;
      waited   <= 2'h0;
    end else begin
      memAck   <= 1'b0;
      memRdata <= ~memRdata; // Read data is garbage outside the ack cycle
      waited   <= 2'h0;
      if (memReq && !memAck) begin
        if (waited == waitCycles) begin
          memAck <= 1'b1;
          if (memWe) begin
            mem[memAddr] <= memWdata;
          end else begin
            memRdata <= mem[memAddr];
          end
        end else begin
          waited <= waited + 2'h1;
        end
      end
    end
  end
endmodule : jse_core_mem
`default_nettype wire

// >>> jump_stop_logic_arith_exec_test.sv
`timescale 1ns/100ps
`default_nettype none
`include "jse_consts.svh"
`define CHK(N, E, G) begin totalChecks++; if ((G) !== (E)) begin errors++; \
  $display("unexpected %s: expected %h, seen %h", N, E, G); end end
// ==========================================================================
// Bench for the stop, jump and arithmetic execution unit
module jump_stop_logic_arith_exec_test;
  import jse_pkg::*;
  // Clock, reset and console
  logic        sys_clk, rst, selStopSw, restart, t, z;
  logic [5:0]  jumpKeys, op[7];
  logic [1:0]  waitCycles;
  // Storage bus and machine state
  logic        memReq, memWe, memAck, halted;
  logic [14:0] memAddr, pc, jp[6];
  logic [23:0] memWdata, memRdata, accum, aux, seed, e, d[7], v[4], jw[6];
  int          errors, totalChecks, k, c;

  jse_exec DUT (.sys_clk(sys_clk), .rst(rst), .memReq(memReq), .memWe(memWe),
    .memAddr(memAddr), .memWdata(memWdata), .memAck(memAck), .memRdata(memRdata),
    .selStopSw(selStopSw), .jumpKeys(jumpKeys), .restart(restart), .halted(halted),
    .pc(pc), .accum(accum), .aux(aux));
  jse_core_mem coreMem (.sys_clk(sys_clk), .rst(rst), .memReq(memReq), .memWe(memWe),
    .memAddr(memAddr), .memWdata(memWdata), .memAck(memAck), .memRdata(memRdata),
    .waitCycles(waitCycles));

  // Clock, 25 ns period
  always #12.5 sys_clk = ~sys_clk;

  function automatic logic [23:0] lfsr(input logic [23:0] s);
    return {s[22:0], s[23] ^ s[22] ^ s[21] ^ s[16]};
  endfunction : lfsr
  // Ones' complement sum with end-around carry
  function automatic logic [23:0] oc_add(input logic [23:0] x, input logic [23:0] y);
    logic [24:0] s;
    s = {1'b0, x} + {1'b0, y};
    return s[23:0] + {23'h0, s[24]};
  endfunction : oc_add
  function automatic logic [23:0] ins(input logic [5:0] o, input logic [2:0] s,
                                      input logic [14:0] m);
    return {o, s, m};
  endfunction : ins

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : step
  task automatic boot();
    rst <= 1'b1;
    seed = lfsr(seed);
    waitCycles <= seed[1:0]; // Prompt or slow storage
    step(2);
    rst <= 1'b0;
  endtask : boot
  task automatic wait_halt();
    int n;
    n = 0;
    while (halted !== 1'b1 && n < 500) begin
      step(1);
      n++;
    end
    `CHK("halted", 1'b1, halted)
  endtask : wait_halt
  task automatic resume();
    restart <= 1'b1;
    step(1);
    restart <= 1'b0;
    step(2);
    wait_halt();
  endtask : resume
  // Accumulator load, instruction under test at 1, markers at 2, 40, 41
  task automatic jump_run(input logic [23:0] w, input logic [23:0] a);
    for (int i = 0; i < 512; i++) coreMem.mem[i] = 24'h000000;
    coreMem.mem[0] = ins(`JSE_OP_ADD, 3'h0, 15'h0080);
    coreMem.mem[1] = w;
    coreMem.mem[2] = ins(`JSE_OP_HALT, `JSE_SUB_HALT, 15'h0011);
    coreMem.mem[15'h40] = ins(`JSE_OP_HALT, `JSE_SUB_HALT, 15'h0022);
    coreMem.mem[15'h41] = ins(`JSE_OP_HALT, `JSE_SUB_HALT, 15'h0033);
    coreMem.mem[15'h60] = 24'h000040;
    coreMem.mem[15'h80] = a;
    boot();
    wait_halt();
  endtask : jump_run
  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", totalChecks, errors);
    if (errors == 0 && totalChecks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up

  // Watchdog against a hung sequencer
  initial begin
    step(40000);
    errors++;
    wrap_up();
  end

  // Main sequence
  initial begin
    sys_clk = 0; rst = 1; selStopSw = 0; restart = 0; jumpKeys = 0; waitCycles = 0;
    seed = 24'h00001D; errors = 0; totalChecks = 0;
    op = '{`JSE_OP_ADD, `JSE_OP_ADD, `JSE_OP_SUB, `JSE_OP_OR, `JSE_OP_XOR, `JSE_OP_AND,
           `JSE_OP_RAD};
    step(20);
    `CHK("reset state", 67'h0, {pc, accum, aux, halted, memReq, memWe})
    // Arithmetic and logic chain, each step followed by a halt
    for (int r = 0; r < 6; r++) begin
      jump_run(24'h000000, 24'h000000);
      for (k = 0; k < 7; k++) begin
        seed = lfsr(seed);
        d[k] = (r == 0) ? 24'hFFFFFF : seed;
        coreMem.mem[256 + k] = d[k];
        coreMem.mem[2 * k] = ins(op[k], 3'h0, 15'(256 + k));
        coreMem.mem[2 * k + 1] = ins(`JSE_OP_HALT, `JSE_SUB_HALT, 15'(2 * k + 2));
      end
      boot();
      e = 24'h000000;
      for (k = 0; k < 7; k++) begin
        if (k == 0) wait_halt();
        else resume();
        case (k)
          0, 1: e = oc_add(e, d[k]);
          2: e = oc_add(e, ~d[k]);
          3: e = e | d[k];
          4: e = e ^ d[k];
          5: e = e & d[k];
          default: `CHK("storage sum", oc_add(d[6], e), coreMem.mem[262])
        endcase
        `CHK("accumulator", e, accum)
        `CHK("restart address", 15'(2 * k + 2), pc)
      end
    end
    // Compare jumps on both zeros, a positive and a negative value
    v[0] = 24'h000000;
    v[1] = 24'hFFFFFF;
    for (k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      if (k > 1) v[k] = (k == 2) ? {1'b0, seed[22:1], 1'b1} : {1'b1, seed[22:1], 1'b0};
      z = (v[k] == 24'h000000) || (v[k] == 24'hFFFFFF);
      for (c = 0; c < 8; c++) begin
        case (jse_cond_t'(c[1:0]))
          COND_EQUAL: t = z;
          COND_NOT_EQUAL: t = !z;
          COND_GREATER_OR_EQUAL: t = !v[k][23];
          default: t = v[k][23];
        endcase
        jump_run(ins(`JSE_OP_CMP, c[2:0], 15'h0040), v[k]);
        `CHK("compare jump", t ? 15'h0022 : 15'h0011, pc)
      end
    end
    // Console key jumps with random keys
    for (k = 1; k < 7; k++) begin
      seed = lfsr(seed);
      e = seed; // Keep the keys: the boot in jump_run below steps the seed on
      jumpKeys <= seed[5:0];
      jump_run(ins(`JSE_OP_HALT, 3'(k), 15'h0040), 24'h000000);
      `CHK("key jump", e[k - 1] ? 15'h0022 : 15'h0011, pc)
    end
    jumpKeys <= 6'h00;
    // Multiply of a positive and a negative operand by itself
    for (k = 0; k < 2; k++) begin
      seed = lfsr(seed);
      e = {1'b0, seed[22:0]};
      d[0] = k[0] ? ~e : e;
      jump_run(ins(`JSE_OP_MUL, 3'h0, 15'h0080), d[0]);
      `CHK("product", {24'h0, e} * {24'h0, e}, {aux, accum})
    end
    // Plain, indirect, index and return jumps
    jw = '{ins(`JSE_OP_UJP, 3'h0, 15'h0040), ins(`JSE_OP_UJP, 3'h4, 15'h0060),
           ins(`JSE_OP_IDX, 3'h0, 15'h0040), ins(`JSE_OP_IDX, 3'h1, 15'h0040),
           ins(`JSE_OP_IDX, 3'h6, 15'h0040), ins(`JSE_OP_HALT, `JSE_SUB_RTJ, 15'h0040)};
    jp = '{15'h0022, 15'h0022, 15'h0011, 15'h0011, 15'h0011, 15'h0033};
    for (k = 0; k < 6; k++) begin
      jump_run(jw[k], 24'h000000);
      `CHK("jump target", jp[k], pc)
    end
    `CHK("return word", 24'h000002, coreMem.mem[15'h40])
    // Selective stop off and on, then unconditional stop
    for (k = 0; k < 3; k++) begin
      selStopSw <= k[0];
      jump_run({`JSE_OP_STOP, (k == 2) ? `JSE_STOP_ALL : `JSE_STOP_SEL, 12'h000}, 24'h0);
      `CHK("stop address", (k == 0) ? 15'h0011 : 15'h0002, pc)
      step(4);
      `CHK("idle while halted", 2'b10, {halted, memReq})
      if (k > 0) resume();
      `CHK("resume address", 15'h0011, pc)
    end
    wrap_up();
  end
endmodule : jump_stop_logic_arith_exec_test
`default_nettype wire
